// [core/clk_switch_refclk.sv]
// clk_switch_refclk: clock switch gating by the configuration field and the
// reference clock output divider, behind an AXI4-Lite slave.
// assumes all inputs synchronous to aclk; primary_osc is sampled, not a clock.
//
// Notes on behaviour
// - run-time source switching is allowed only when the config field is 00.
// - config field upper bit set disables switching and the fail-safe monitor.
// - unprogrammed config field, switching and monitor off, is the default.
// - with switching off, next source select bits do not pick the clock.
// - with switching off, current source status shows the start-up source.
// - with switching off, switch request writes are ignored; bit reads zero.
`timescale 1ns/100ps
`default_nettype none
module clk_switch_refclk
  import clk_switch_pkg::*;
#(
  parameter logic [SRC_W-1:0] STARTUP_SOURCE = 3'h0,
  parameter int CNT_W = 15
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [clk_switch_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [clk_switch_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device state and base clocks
  input wire logic sleep_mode,
  input wire logic primary_osc,
  // clock control outputs
  output logic [clk_switch_pkg::SRC_W-1:0] system_source_sel,
  output logic switching_enabled,
  output logic fail_safe_monitor_en,
  output logic refclk_out
);
  import clk_switch_pkg::*;

  // divide by 2^15 needs toggling every 2^14 base edges
  if (CNT_W < (1 << REF_DIV_W) - 1) begin : g_bad_cnt
    $error("CNT_W too small for the divider range");
  end

  // registers
  logic [SRC_W-1:0] next_src_q;
  logic [SRC_W-1:0] cur_src_q;
  logic switch_req_q;
  logic [15:0] refclk_ctrl_q;
  logic [SMC_W-1:0] smc_q;
  logic [SRC_W-1:0] startup_q;

  // bus state
  logic aw_held_q, w_held_q;
  logic [ADDR_W-1:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q, arready_q;
  logic awready_q, wready_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // refclk state
  logic [CNT_W-1:0] div_cnt_q;
  logic posc_prev_q;
  logic refclk_q;

  // switching gate
  wire logic sw_on = (smc_q == SMC_SWITCH_ON);
  wire logic [SRC_W-1:0] cur_view =
    sw_on ? cur_src_q : startup_q;

  // write decode
  wire logic aw_take = s_axi_awvalid && awready_q;
  wire logic w_take = s_axi_wvalid && wready_q;
  wire logic wr_go = aw_held_q && w_held_q && !bvalid_q;
  // next handshake state, so the readies can leave straight from flops
  wire logic aw_held_d = !wr_go && (aw_held_q || aw_take);
  wire logic w_held_d = !wr_go && (w_held_q || w_take);
  wire logic bvalid_d = wr_go || (bvalid_q && !s_axi_bready);
  wire logic wr_osc = wr_go && (awaddr_q == OSC_CTRL_OFS);
  wire logic wr_ref = wr_go && (awaddr_q == REFCLK_CTRL_OFS);
  wire logic wr_cfg = wr_go && (awaddr_q == CONFIG_TWO_OFS);
  wire logic wr_hit = wr_osc || wr_ref || wr_cfg;
  wire logic [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire logic [15:0] wmerge_ref =
    (refclk_ctrl_q & ~wmask) | (wdata_q[15:0] & wmask);
  wire logic [15:0] osc_read = {1'b0, cur_view, 1'b0, next_src_q,
    7'h00, switch_req_q};
  wire logic [15:0] cfg_read = {9'h000, startup_q, 2'h0, smc_q};
  wire logic [15:0] wmerge_osc =
    (osc_read & ~wmask) | (wdata_q[15:0] & wmask);
  wire logic [15:0] wmerge_cfg =
    (cfg_read & ~wmask) | (wdata_q[15:0] & wmask);
  // request is only taken while switching is allowed
  wire logic req_write = wr_osc && sw_on &&
    wmerge_osc[SWITCH_REQ_BIT];

  // read decode
  wire logic ar_take = s_axi_arvalid && arready_q;
  wire logic rd_osc = (s_axi_araddr == OSC_CTRL_OFS);
  wire logic rd_ref = (s_axi_araddr == REFCLK_CTRL_OFS);
  wire logic rd_cfg = (s_axi_araddr == CONFIG_TWO_OFS);
  wire logic [15:0] rd_word = rd_osc ? osc_read :
    rd_ref ? refclk_ctrl_q : rd_cfg ? cfg_read : 16'h0000;
  wire logic rd_hit = rd_osc || rd_ref || rd_cfg;

  // refclk decode
  wire logic ref_en = refclk_ctrl_q[REF_EN_BIT];
  wire logic ref_sel = refclk_ctrl_q[REF_SEL_BIT];
  wire logic [REF_DIV_W-1:0] ref_div =
    refclk_ctrl_q[REF_DIV_LSB +: REF_DIV_W];
  wire logic ref_run = ref_en &&
    (!sleep_mode || refclk_ctrl_q[REF_SLP_BIT]);
  wire logic base_edge = ref_sel ? (primary_osc && !posc_prev_q) : 1'b1;
  wire logic [CNT_W-1:0] half_cnt = (ref_div == '0) ? '0 :
    CNT_W'((1 << (ref_div - 4'h1)) - 1);
  wire logic cnt_wrap = (div_cnt_q >= half_cnt);

  // write channel handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end else begin
      awready_q <= !aw_held_d && !bvalid_d;
      wready_q <= !w_held_d && !bvalid_d;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel; one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {16'h0000, rd_word};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // configuration word; reset to unprogrammed state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smc_q <= SMC_UNPROGRAMMED;
      startup_q <= STARTUP_SOURCE;
    end else if (wr_cfg) begin
      smc_q <= wmerge_cfg[SMC_LSB +: SMC_W];
      startup_q <= wmerge_cfg[STARTUP_LSB +: SRC_W];
    end
  end

  // oscillator control; switch completes one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_src_q <= NEXT_SRC_RESET;
      cur_src_q <= STARTUP_SOURCE;
      switch_req_q <= 1'b0;
    end else begin
      if (wr_osc) begin
        next_src_q <= wmerge_osc[NEXT_SRC_LSB +: SRC_W];
      end
      if (!sw_on) begin
        // held off; status tracks start-up source
        switch_req_q <= 1'b0;
        cur_src_q <= startup_q;
      end else if (switch_req_q) begin
        cur_src_q <= next_src_q;
        switch_req_q <= req_write;
      end else begin
        switch_req_q <= req_write;
      end
    end
  end

  // reference clock control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refclk_ctrl_q <= REFCLK_CTRL_RESET;
    end else if (wr_ref) begin
      refclk_ctrl_q <= wmerge_ref & REFCLK_CTRL_MASK;
    end
  end

  // reference clock divider; sysclk undivided is limited to aclk/2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_q <= '0;
      posc_prev_q <= 1'b0;
      refclk_q <= 1'b0;
    end else begin
      posc_prev_q <= primary_osc;
      if (!ref_run) begin
        div_cnt_q <= '0;
        refclk_q <= 1'b0;
      end else if (ref_div == '0 && ref_sel) begin
        refclk_q <= primary_osc;
      end else if (base_edge) begin
        if (cnt_wrap) begin
          div_cnt_q <= '0;
          refclk_q <= !refclk_q;
        end else begin
          div_cnt_q <= div_cnt_q + 1'b1;
        end
      end
    end
  end

  // registered status outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_source_sel <= STARTUP_SOURCE;
      switching_enabled <= 1'b0;
      fail_safe_monitor_en <= 1'b0;
    end else begin
      system_source_sel <= cur_view;
      switching_enabled <= sw_on;
      // monitor only off-gated by the upper bit
      fail_safe_monitor_en <= !smc_q[SMC_W-1];
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign refclk_out = refclk_q;
endmodule
`default_nettype wire

// [core/clk_switch_pkg.sv]
// clk_switch_pkg: register map, field positions and reset values of the
// clock switch gating and reference clock output block.
// assumes a 32-bit AXI4-Lite register bus; registers use the low 16 bits.
package clk_switch_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OSC_CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] REFCLK_CTRL_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] CONFIG_TWO_OFS = 4'h8;

  // oscillator_control_register
  localparam int CUR_SRC_LSB = 12;
  localparam int NEXT_SRC_LSB = 8;
  localparam int SWITCH_REQ_BIT = 0;
  localparam int SRC_W = 3;
  localparam logic [SRC_W-1:0] NEXT_SRC_RESET = 3'h0;

  // reference_clock_output_control
  localparam int REF_EN_BIT = 15;
  localparam int REF_SLP_BIT = 13;
  localparam int REF_SEL_BIT = 12;
  localparam int REF_DIV_LSB = 8;
  localparam int REF_DIV_W = 4;
  localparam logic [15:0] REFCLK_CTRL_RESET = 16'h0000;
  localparam logic [15:0] REFCLK_CTRL_MASK = 16'hBF00;

  // config_word_two
  localparam int SMC_LSB = 0;
  localparam int SMC_W = 2;
  localparam int STARTUP_LSB = 4;
  localparam logic [SMC_W-1:0] SMC_UNPROGRAMMED = 2'h3;
  localparam logic [SMC_W-1:0] SMC_SWITCH_ON = 2'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [verification/clk_switch_refclk_chk.sv]
// clk_switch_refclk_chk: port assertions for clk_switch_refclk.
// assumes one clock aclk, sync active-low aresetn.
`timescale 1ns/100ps
`default_nettype none
module clk_switch_refclk_chk
  import clk_switch_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock control
  input wire logic [clk_switch_pkg::SRC_W-1:0] system_source_sel,
  input wire logic switching_enabled,
  input wire logic fail_safe_monitor_en,
  input wire logic refclk_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  mon_with_sw_a: assert property (switching_enabled |-> fail_safe_monitor_en)
    else $error("switching on with monitor off");
  both_off_a: assert property (!$past(aresetn) |->
    !switching_enabled && !fail_safe_monitor_en)
    else $error("switching or monitor on after reset");
  // a register write may move the start-up field, so skip that edge
  src_fixed_a: assert property (!switching_enabled &&
    !$past(switching_enabled) && !$past(s_axi_bvalid) && $past(aresetn)
    |-> $stable(system_source_sel)) else $error("source moved while locked");
  ref_low_a: assert property (!$past(aresetn) |-> !refclk_out)
    else $error("reference clock high after reset");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  cover property (switching_enabled);
  cover property ($rose(refclk_out));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind clk_switch_refclk clk_switch_refclk_chk u_chk (.*);
`default_nettype wire

// [verification/clk_switch_refclk_test.sv]
// clk_switch_refclk_test: self-checking bench for clk_switch_refclk.
// assumes the package and design are compiled first.
`timescale 1ns/100ps
`default_nettype none
module clk_switch_refclk_test;
  import clk_switch_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic sleep_mode = 0, primary_osc = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, refclk_out, switching_enabled;
  wire logic fail_safe_monitor_en;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [2:0] system_source_sel;
  int error_cnt = 0;
  int check_count = 0;
  clk_switch_refclk #(.STARTUP_SOURCE(3'h5)) u_clk_switch_refclk (.*);
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) primary_osc <= ~primary_osc;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic hang;
    check(0, 1);
    print_verdict();
  endtask
  // bready up with the request; one idle edge after so it is not
  // lowered and raised again in the same time step
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] er = RESP_OKAY);
    bit done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) done = 1;
    end
    if (!done) hang();
    check(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp,
    input logic [1:0] er = RESP_OKAY);
    bit done = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) done = 1;
    end
    if (!done) hang();
    check(s_axi_rresp, er);
    check(s_axi_rdata, exp);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // first interval after a change may be short: time the second
  task automatic period(input int exp);
    int n = 0, t0 = 0, p = 0;
    logic prev = refclk_out;
    for (int i = 0; i < 300 && p == 0; i++) begin
      @(posedge aclk);
      if (refclk_out && !prev) n++;
      if (refclk_out && !prev && n == 2) t0 = i;
      if (refclk_out && !prev && n == 3) p = i - t0;
      prev = refclk_out;
    end
    if (p == 0) hang();
    check(p, exp);
  endtask
  task automatic quiet;
    logic s = 0;
    repeat (2) @(posedge aclk);
    repeat (12) begin
      @(posedge aclk);
      s = s | refclk_out;
    end
    check(s, 0);
  endtask
  task automatic t_reset;
    check(switching_enabled, 0);
    check(fail_safe_monitor_en, 0);
    check(system_source_sel, 3'h5);
    rd(OSC_CTRL_OFS, 32'h5000);
    rd(CONFIG_TWO_OFS, 32'h0053);
    rd(REFCLK_CTRL_OFS, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_locked;
    wr(OSC_CTRL_OFS, 32'h0201);
    rd(OSC_CTRL_OFS, 32'h5200);
    check(system_source_sel, 3'h5);
    wr(CONFIG_TWO_OFS, 32'h0031);
    repeat (2) @(posedge aclk);
    check(fail_safe_monitor_en, 1);
    check(switching_enabled, 0);
    check(system_source_sel, 3'h3);
    rd(OSC_CTRL_OFS, 32'h3200);
    wr(CONFIG_TWO_OFS, 32'h0032);
    repeat (2) @(posedge aclk);
    check({switching_enabled, fail_safe_monitor_en}, 0);
    $display("locked test done");
  endtask
  task automatic t_switch;
    wr(CONFIG_TWO_OFS, 32'h0030);
    repeat (2) @(posedge aclk);
    check(switching_enabled, 1);
    wr(OSC_CTRL_OFS, 32'h0201);
    repeat (3) @(posedge aclk);
    check(system_source_sel, 3'h2);
    rd(OSC_CTRL_OFS, 32'h2200);
    wr(4'hC, 32'h0, RESP_SLVERR);
    rd(4'hC, 32'h0, RESP_SLVERR);
    $display("switch test done");
  endtask
  task automatic t_refclk;
    logic [31:0] ctl[5] = '{32'h8000, 32'h8200, 32'h8300, 32'h9000, 32'h9100};
    int per[5] = '{2, 4, 8, 2, 4};
    wr(REFCLK_CTRL_OFS, 32'hFFFF);
    rd(REFCLK_CTRL_OFS, 32'hBF00);
    foreach (ctl[i]) begin
      wr(REFCLK_CTRL_OFS, ctl[i]);
      period(per[i]);
    end
    sleep_mode <= 1'b1;
    wr(REFCLK_CTRL_OFS, 32'h8100);
    quiet();
    wr(REFCLK_CTRL_OFS, 32'hA200);
    period(4);
    sleep_mode <= 1'b0;
    wr(REFCLK_CTRL_OFS, 32'h0100);
    quiet();
    $display("refclk test done");
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_locked();
    t_switch();
    t_refclk();
    print_verdict();
  end
endmodule
`default_nettype wire
